/* tfc_fifo_ctrl.sv */
// Host FIFO, level and warning logic, bit framing and misc control
`timescale 1ns/1ps
`include "tfc_regs.svh"

// ======================================================
// Generic synchronous FIFO
module tfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  // Control and level
  input  wire logic             flush,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
    $error("tfc_fifo: DEPTH must be a power of two, WIDTH positive");
  end

  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0]   cnt;
    logic          full;
    logic          empty;
    logic          room;
  } tfc_fifo_state_t;
  tfc_fifo_state_t  st_q;
  tfc_fifo_state_t  st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign push      = in_valid && !st_q.full && !flush;
  assign pop       = out_ready && !st_q.empty && !flush;
  assign in_ready  = st_q.room;
  assign out_valid = !st_q.empty;
  assign out_data  = mem[st_q.rd];
  assign level     = st_q.cnt;

  always_comb begin
    st_d = st_q;
    if (flush) begin
      st_d.rd  = '0;
      st_d.wr  = '0;
      st_d.cnt = '0;
    end else begin
      st_d.wr  = push ? st_q.wr + AW'(1) : st_q.wr;
      st_d.rd  = pop ? st_q.rd + AW'(1) : st_q.rd;
      st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    st_d.full  = (st_d.cnt == (AW+1)'(DEPTH));
    st_d.empty = (st_d.cnt == '0);
    st_d.room  = !st_d.full;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{rd: '0, wr: '0, cnt: '0, full: 1'b0, empty: 1'b1,
                room: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end
  // Storage is not reset; empty flag guards stale words
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st_q.wr] <= in_data;
    end
  end
endmodule

// ======================================================
// Top of the control block
module tfc_fifo_ctrl
  import tfc_pkg::*;
#(
  parameter int FIFO_DEPTH = `TFC_FIFO_DEPTH,
  parameter int ID_BYTES   = `TFC_ID_BYTES
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // Host register port
  input  wire tfc_host_req_t     host_req,
  output logic [7:0]             host_rdata,
  // Serial transmit path
  input  wire logic              tx_byte_req,
  output logic [7:0]             tx_byte,
  output logic                   tx_byte_valid,
  output logic                   tx_start,
  output logic [2:0]             tx_final_bit_count,
  input  wire logic              tx_done,
  // Serial receive path
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_byte,
  output logic                   rx_ready,
  input  wire logic              rx_frame_end,
  input  wire logic [2:0]        rx_valid_bits,
  output logic [2:0]             rx_first_bit_offset,
  // Command sequencer and timer
  input  wire logic              cmd_transceive,
  output logic                   timer_halt_strobe,
  output logic                   timer_launch_strobe,
  // Identifier and status
  input  wire logic [8*ID_BYTES-1:0] stored_peer_identifier,
  output logic [6:0]             fill_count,
  output logic                   overflow_error,
  output logic                   near_full_flag,
  output logic                   near_empty_flag,
  output logic [2:0]             link_fsm_state,
  output logic                   initiator_role
);
  if (FIFO_DEPTH != 64 || ID_BYTES < 1 || ID_BYTES > 15) begin
    $error("tfc_fifo_ctrl: unsupported FIFO_DEPTH or ID_BYTES");
  end
  tfc_state_t st_q;
  tfc_state_t st_d;

  // ======================================================
  // Decode of the host access
  logic wr_data, rd_data, wr_level, wr_thr, wr_ctrl, wr_frm, flush;
  assign wr_data  = host_req.wr && host_req.addr == `TFC_OFS_DATA;
  assign rd_data  = host_req.rd && host_req.addr == `TFC_OFS_DATA;
  assign wr_level = host_req.wr && host_req.addr == `TFC_OFS_LEVEL;
  assign wr_thr   = host_req.wr && host_req.addr == `TFC_OFS_THRESH;
  assign wr_ctrl  = host_req.wr && host_req.addr == `TFC_OFS_CTRL;
  assign wr_frm   = host_req.wr && host_req.addr == `TFC_OFS_FRAMING;
  assign flush    = wr_level && host_req.wdata[`TFC_BIT_FLUSH];

  // ======================================================
  // Receive staging buffer and main FIFO
  logic       st_valid, st_ready;
  logic [7:0] st_data;
  logic       m_in_valid, m_in_ready, m_out_valid, m_out_ready;
  logic [7:0] m_in_data, m_out_data, id_byte;
  logic [6:0] m_level;
  logic       host_pop, tx_pop, copy_go;

  // Drained only when the main FIFO has room, so a full FIFO
  // fills the stage and finally drops rx_ready
  tfc_fifo #(.WIDTH(8), .DEPTH(`TFC_STAGE_DEPTH)) u_stage (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (rx_valid),
    .in_data   (rx_byte),
    .in_ready  (rx_ready),
    .out_valid (st_valid),
    .out_data  (st_data),
    .out_ready (st_ready),
    .flush     (flush),
    .level     ()
  );

  tfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_main (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (m_in_valid),
    .in_data   (m_in_data),
    .in_ready  (m_in_ready),
    .out_valid (m_out_valid),
    .out_data  (m_out_data),
    .out_ready (m_out_ready),
    .flush     (flush),
    .level     (m_level)
  );

  // Host writes first, then the identifier copy, then received data
  assign id_byte     = stored_peer_identifier[8*st_q.copy_idx +: 8];
  assign copy_go     = st_q.copy_busy && !wr_data && m_in_ready;
  assign st_ready    = m_in_ready && !wr_data && !st_q.copy_busy;
  assign m_in_valid  = wr_data || st_q.copy_busy || st_valid;
  assign m_in_data   = wr_data ? host_req.wdata :
                       st_q.copy_busy ? id_byte : st_data;
  assign host_pop    = rd_data && m_out_valid;
  assign tx_pop      = tx_byte_req && m_out_valid && !host_pop;
  assign m_out_ready = host_pop || tx_pop;

  // ======================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.halt          = 1'b0;
    st_d.launch        = 1'b0;
    st_d.tx_start      = 1'b0;
    st_d.tx_byte_valid = 1'b0;
    // Overflow: a drop wins over nothing; flush clears it
    if (wr_data && !m_in_ready) begin
      st_d.ovf = 1'b1;
    end else if (flush) begin
      st_d.ovf = 1'b0;
    end
    st_d.fill       = m_level;
    st_d.near_full  = (7'(FIFO_DEPTH) - m_level)
                      <= {1'b0, st_q.thresh};
    st_d.near_empty = m_level <= {1'b0, st_q.thresh};
    if (wr_thr) st_d.thresh = host_req.wdata[5:0];
    if (wr_ctrl) begin
      st_d.halt   = host_req.wdata[`TFC_BIT_HALT];
      st_d.launch = host_req.wdata[`TFC_BIT_LAUNCH];
      st_d.role   = host_req.wdata[`TFC_BIT_ROLE];
      if (host_req.wdata[`TFC_BIT_COPY] && !st_q.copy_busy) begin
        st_d.copy_busy = 1'b1;
        st_d.copy_idx  = '0;
      end
    end
    // Index may step past the end; the next copy restarts it
    if (copy_go) begin
      st_d.copy_busy = st_q.copy_idx != 4'(ID_BYTES - 1);
      st_d.copy_idx  = st_q.copy_idx + 4'h1;
    end
    if (rx_frame_end) st_d.rx_last = rx_valid_bits;
    if (wr_frm) begin
      st_d.rx_align = host_req.wdata[`TFC_ALIGN_LSB +: 3];
      st_d.tx_last  = host_req.wdata[2:0];
    end
    if (tx_pop) begin
      st_d.tx_byte       = m_out_data;
      st_d.tx_byte_valid = 1'b1;
    end
    // Register read data, sampled on the read cycle
    if (host_req.rd) begin
      unique case (host_req.addr)
        `TFC_OFS_DATA:    st_d.rdata = host_pop ? m_out_data : 8'h00;
        `TFC_OFS_LEVEL:   st_d.rdata = {1'b0, m_level};
        `TFC_OFS_THRESH:  st_d.rdata = {2'b00, st_q.thresh};
        `TFC_OFS_CTRL:    st_d.rdata = {2'b00, st_q.copy_busy, st_q.role,
                                        1'b0, st_q.rx_last};
        `TFC_OFS_FRAMING: st_d.rdata = {1'b0, st_q.rx_align, 1'b0,
                                        st_q.tx_last};
        default:          st_d.rdata = 8'h00;
      endcase
    end
    // Transmit / receive sequencing
    unique case (st_q.link)
      LK_IDLE: if (cmd_transceive) st_d.link = LK_WAIT;
      LK_WAIT: begin
        if (!cmd_transceive) st_d.link = LK_IDLE;
        else if (wr_frm && host_req.wdata[`TFC_BIT_TRIGGER]) begin
          st_d.link     = LK_SEND;
          st_d.tx_start = 1'b1;
        end
      end
      LK_SEND: begin
        if (!cmd_transceive) st_d.link = LK_IDLE;
        else if (tx_done) st_d.link = LK_RECV;
      end
      LK_RECV: begin
        if (!cmd_transceive) st_d.link = LK_IDLE;
        else if (rx_frame_end) st_d.link = LK_WAIT;
      end
      default: st_d.link = LK_IDLE;
    endcase
    unique case (st_d.link)
      LK_WAIT: st_d.link_code = `TFC_CODE_WAIT;
      LK_SEND: st_d.link_code = `TFC_CODE_SEND;
      LK_RECV: st_d.link_code = `TFC_CODE_RECV;
      default: st_d.link_code = `TFC_CODE_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q        <= '0;
      st_q.link   <= LK_IDLE;
      st_q.thresh <= `TFC_THRESH_RST;
      st_q.near_empty <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ======================================================
  // Outputs, all straight from state flops
  assign host_rdata          = st_q.rdata;
  assign tx_byte             = st_q.tx_byte;
  assign tx_byte_valid       = st_q.tx_byte_valid;
  assign tx_start            = st_q.tx_start;
  assign tx_final_bit_count  = st_q.tx_last;
  // Nonzero only meaningful for bitwise anticollision
  assign rx_first_bit_offset = st_q.rx_align;
  assign timer_halt_strobe   = st_q.halt;
  assign timer_launch_strobe = st_q.launch;
  assign fill_count          = st_q.fill;
  assign overflow_error      = st_q.ovf;
  assign near_full_flag      = st_q.near_full;
  assign near_empty_flag     = st_q.near_empty;
  assign link_fsm_state      = st_q.link_code;
  assign initiator_role      = st_q.role;

  // ======================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_flush_clears_ovf: assert property (
    flush |=> !overflow_error && m_level == 7'h00 ##1 fill_count == 7'h00)
    else $error("flush did not clear overflow or level");
  a_full_write_ovf: assert property (
    wr_data && !m_in_ready |=> overflow_error && m_level == $past(m_level)
                                 - 7'($past(m_out_ready)))
    else $error("write to full FIFO not flagged or not dropped");
  a_level_counts_up: assert property (
    wr_data && m_in_ready && !m_out_ready
      |=> m_level == $past(m_level) + 7'h01 ##1 fill_count == $past(m_level))
    else $error("data write did not raise fill count");
  a_empty_read_zero: assert property (
    rd_data && m_level == 7'h00 |=> host_rdata == 8'h00)
    else $error("read of empty FIFO returned data");
  a_near_full_calc: assert property (
    ##1 near_full_flag ==
      ((7'(FIFO_DEPTH) - fill_count) <= {1'b0, $past(st_q.thresh)}))
    else $error("near-full flag disagrees with level");
  a_near_empty_calc: assert property (
    ##1 near_empty_flag == (fill_count <= {1'b0, $past(st_q.thresh)}))
    else $error("near-empty flag disagrees with level");
  a_launch_one_pulse: assert property (
    wr_ctrl && host_req.wdata[`TFC_BIT_LAUNCH]
      |=> timer_launch_strobe ##1 (!timer_launch_strobe || $past(wr_ctrl)))
    else $error("launch strobe not a single pulse");
  a_halt_one_pulse: assert property (
    wr_ctrl && host_req.wdata[`TFC_BIT_HALT]
      |=> timer_halt_strobe ##1 (!timer_halt_strobe || $past(wr_ctrl)))
    else $error("halt strobe not a single pulse");
  a_trigger_gated: assert property (
    tx_start |-> $past(cmd_transceive) && $past(link_fsm_state) == 3'h1)
    else $error("transmission started outside transceive wait");
  a_wait_code_seen: assert property (
    st_q.link == LK_WAIT |-> link_fsm_state == 3'h1)
    else $error("waiting state not reported as 001");
  a_copy_self_clear: assert property (
    copy_go && st_q.copy_idx == 4'(ID_BYTES - 1) |=> !st_q.copy_busy)
    else $error("copy bit did not clear after last byte");

  c_overflow:   cover property (wr_data && !m_in_ready);
  c_copy_done:  cover property (st_q.copy_busy ##1 !st_q.copy_busy);
  c_tx_started: cover property (tx_start ##[1:50] tx_byte_valid);
  c_rx_stalled: cover property (!rx_ready && rx_valid);
endmodule

/* tfc_regs.svh */
// Register offsets, field positions, reset values and counts of the FIFO block
`ifndef TFC_REGS_SVH
`define TFC_REGS_SVH

// ======================================================
// Register offsets on the host port
`define TFC_OFS_DATA      6'h09
`define TFC_OFS_LEVEL     6'h0A
`define TFC_OFS_THRESH    6'h0B
`define TFC_OFS_CTRL      6'h0C
`define TFC_OFS_FRAMING   6'h0D

// ======================================================
// Field positions
`define TFC_BIT_FLUSH     7
`define TFC_BIT_HALT      7
`define TFC_BIT_LAUNCH    6
`define TFC_BIT_COPY      5
`define TFC_BIT_ROLE      4
`define TFC_BIT_TRIGGER   7
`define TFC_ALIGN_LSB     4

// ======================================================
// Reset values and counts
`define TFC_THRESH_RST    6'h08
`define TFC_FIFO_DEPTH    64
`define TFC_STAGE_DEPTH   8
`define TFC_ID_BYTES      10

// ======================================================
// Link state codes as software reads them
`define TFC_CODE_IDLE     3'h0
`define TFC_CODE_WAIT     3'h1
`define TFC_CODE_SEND     3'h3
`define TFC_CODE_RECV     3'h5

`endif

/* tfc_pkg.sv */
// Types shared by the FIFO and framing control block
package tfc_pkg;

  // ======================================================
  // Host register request, one access per cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tfc_host_req_t;

  // ======================================================
  // Transmit / receive sequencing
  typedef enum logic [3:0] {
    LK_IDLE = 4'b0001,
    LK_WAIT = 4'b0010,
    LK_SEND = 4'b0100,
    LK_RECV = 4'b1000
  } tfc_link_t;

  // ======================================================
  // Whole state of the control block
  typedef struct packed {
    tfc_link_t  link;
    logic [2:0] link_code;
    logic [5:0] thresh;
    logic       role;
    logic       copy_busy;
    logic [3:0] copy_idx;
    logic [2:0] rx_last;
    logic [2:0] rx_align;
    logic [2:0] tx_last;
    logic       ovf;
    logic       near_full;
    logic       near_empty;
    logic [6:0] fill;
    logic [7:0] rdata;
    logic [7:0] tx_byte;
    logic       tx_byte_valid;
    logic       tx_start;
    logic       halt;
    logic       launch;
  } tfc_state_t;

endpackage

/* tfc_serial_model.sv */
// Model of the serial transmit and receive paths beside the FIFO block
`timescale 1ns/1ps
module tfc_serial_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Transmit side
  output logic            tx_byte_req,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_byte_valid,
  output logic            tx_done,
  // Receive side
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  input  wire logic       rx_ready,
  output logic            rx_frame_end,
  output logic [2:0]      rx_valid_bits
);
  logic [7:0] got[$];
  logic       ok;

  initial begin
    tx_byte_req = 1'b0;
    tx_done = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_frame_end = 1'b0;
    rx_valid_bits = 3'h0;
  end

  always @(posedge sys_clk) begin
    if (tx_byte_valid === 1'b1)
      got.push_back(tx_byte);
  end

  // ======================================================
  // Odd bytes take an extra cycle so a slow serializer is seen too
  task automatic pull(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      tx_byte_req = 1'b1;
      @(negedge sys_clk);
      tx_byte_req = 1'b0;
      @(negedge sys_clk);
      if (i[0]) @(negedge sys_clk);
    end
    tx_done = 1'b1;
    @(negedge sys_clk);
    tx_done = 1'b0;
  endtask

  // ======================================================
  // Byte held until a rising edge sees rx_ready high
  task automatic push(input logic [7:0] base, input int n,
                      input logic [2:0] bits);
    @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_byte = base + 8'(i);
      do begin
        ok = rx_ready;
        @(negedge sys_clk);
      end while (ok !== 1'b1);
    end
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    rx_frame_end = 1'b1;
    rx_valid_bits = bits;
    @(negedge sys_clk);
    rx_frame_end = 1'b0;
    rx_valid_bits = ~bits;
  endtask
endmodule

/* transceiver_fifo_framing_ctrl_tb.sv */
// Self-checking bench of the FIFO and framing control block
`timescale 1ns/1ps
`include "tfc_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
  miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, e); \
  end end
module transceiver_fifo_framing_ctrl_tb;
  import tfc_pkg::*;
  logic          sys_clk, reset_n, cmd_transceive;
  tfc_host_req_t host_req;
  logic [7:0]    host_rdata, tx_byte, rx_byte, rd_v, seed;
  logic          tx_byte_req, tx_byte_valid, tx_start, tx_done;
  logic          rx_valid, rx_ready, rx_frame_end, initiator_role;
  logic          overflow_error, near_full_flag, near_empty_flag;
  logic          timer_halt_strobe, timer_launch_strobe;
  logic [2:0]    tx_final_bit_count, rx_valid_bits;
  logic [2:0]    rx_first_bit_offset, link_fsm_state;
  logic [6:0]    fill_count;
  logic [79:0]   ident;
  logic [5:0]    thr_tab[3];
  logic [7:0]    exp_q[$];
  int            miscompares, cmp_count, n_halt, n_launch, n_start;

  tfc_fifo_ctrl #(.FIFO_DEPTH(`TFC_FIFO_DEPTH), .ID_BYTES(`TFC_ID_BYTES))
  u_dut (.sys_clk, .reset_n, .host_req, .host_rdata, .tx_byte_req,
    .tx_byte, .tx_byte_valid, .tx_start, .tx_final_bit_count, .tx_done,
    .rx_valid, .rx_byte, .rx_ready, .rx_frame_end, .rx_valid_bits,
    .rx_first_bit_offset, .cmd_transceive, .timer_halt_strobe,
    .timer_launch_strobe, .stored_peer_identifier(ident), .fill_count,
    .overflow_error, .near_full_flag, .near_empty_flag, .link_fsm_state,
    .initiator_role);

  tfc_serial_model u_far (.sys_clk, .reset_n, .tx_byte_req, .tx_byte,
    .tx_byte_valid, .tx_done, .rx_valid, .rx_byte, .rx_ready,
    .rx_frame_end, .rx_valid_bits);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (timer_halt_strobe === 1'b1) n_halt++;
    if (timer_launch_strobe === 1'b1) n_launch++;
    if (tx_start === 1'b1) n_start++;
  end

  // ======================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Expected {near_full, near_empty} for a fill level
  function automatic logic [1:0] flags(input int f, input logic [5:0] t);
    return {(`TFC_FIFO_DEPTH - f) <= int'(t), f <= int'(t)};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    host_req = {1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    host_req = '0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    host_req = {1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    host_req = '0;
    d = host_rdata;
  endtask

  // Level flags lag the FIFO, so let them settle first
  task automatic chk_level(input int f, input logic [5:0] t);
    idle(3);
    `CHK(fill_count, 7'(f))
    `CHK({near_full_flag, near_empty_flag}, flags(f, t))
  endtask

  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  // ======================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    host_req = '0;
    cmd_transceive = 1'b0;
    ident = '0;
    seed = 8'h2C;
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    rd(`TFC_OFS_LEVEL, rd_v);
    `CHK(rd_v, 8'h00)
    rd(`TFC_OFS_THRESH, rd_v);
    `CHK(rd_v, 8'h08)
    rd(`TFC_OFS_CTRL, rd_v);
    `CHK(rd_v, 8'h00)
    rd(6'h3F, rd_v);
    `CHK(rd_v, 8'h00)
    `CHK(near_empty_flag, 1'b1)
    `CHK(rx_ready, 1'b1)
    seed = lfsr(seed);
    thr_tab = '{6'h00, 6'h3F, seed[5:0]};
    // Extreme thresholds first, then a random one
    foreach (thr_tab[k]) begin
      wr(`TFC_OFS_THRESH, {2'b11, thr_tab[k]});
      rd(`TFC_OFS_THRESH, rd_v);
      `CHK(rd_v, {2'b00, thr_tab[k]})
      for (int i = 1; i <= `TFC_FIFO_DEPTH; i++) begin
        seed = lfsr(seed);
        exp_q.push_back(seed);
        wr(`TFC_OFS_DATA, seed);
        chk_level(i, thr_tab[k]);
      end
      wr(`TFC_OFS_DATA, 8'hA5);
      chk_level(`TFC_FIFO_DEPTH, thr_tab[k]);
      `CHK(overflow_error, 1'b1)
      for (int i = 1; i <= `TFC_FIFO_DEPTH; i++) begin
        rd(`TFC_OFS_DATA, rd_v);
        `CHK(rd_v, exp_q.pop_front())
        chk_level(`TFC_FIFO_DEPTH - i, thr_tab[k]);
      end
      rd(`TFC_OFS_DATA, rd_v);
      `CHK(rd_v, 8'h00)
      chk_level(0, thr_tab[k]);
      wr(`TFC_OFS_DATA, seed);
      wr(`TFC_OFS_LEVEL, 8'h80);
      chk_level(0, thr_tab[k]);
      `CHK(overflow_error, 1'b0)
      rd(`TFC_OFS_LEVEL, rd_v);
      `CHK(rd_v, 8'h00)
    end
    wr(`TFC_OFS_CTRL, 8'hD0);
    idle(2);
    `CHK(n_halt, 1)
    `CHK(n_launch, 1)
    `CHK(initiator_role, 1'b1)
    rd(`TFC_OFS_CTRL, rd_v);
    `CHK(rd_v, 8'h10)
    for (int i = 0; i < `TFC_ID_BYTES; i++) begin
      seed = lfsr(seed);
      ident[8*i +: 8] = seed;
    end
    wr(`TFC_OFS_CTRL, 8'h20);
    idle(16);
    rd(`TFC_OFS_CTRL, rd_v);
    `CHK(rd_v, 8'h00)
    `CHK(fill_count, 7'd10)
    for (int i = 0; i < `TFC_ID_BYTES; i++) begin
      rd(`TFC_OFS_DATA, rd_v);
      `CHK(rd_v, ident[8*i +: 8])
    end
    wr(`TFC_OFS_FRAMING, 8'h35);
    rd(`TFC_OFS_FRAMING, rd_v);
    `CHK(rd_v, 8'h35)
    `CHK(rx_first_bit_offset, 3'd3)
    `CHK(tx_final_bit_count, 3'd5)
    // Alignment back to zero for ordinary frames
    wr(`TFC_OFS_FRAMING, 8'h85);
    idle(2);
    `CHK(n_start, 0)
    cmd_transceive = 1'b1;
    idle(2);
    `CHK(link_fsm_state, `TFC_CODE_WAIT)
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      exp_q.push_back(seed);
      wr(`TFC_OFS_DATA, seed);
    end
    wr(`TFC_OFS_FRAMING, 8'h85);
    idle(2);
    `CHK(n_start, 1)
    `CHK(link_fsm_state, `TFC_CODE_SEND)
    u_far.pull(3);
    idle(2);
    `CHK(link_fsm_state, `TFC_CODE_RECV)
    `CHK(u_far.got.size(), 3)
    for (int i = 0; i < 3; i++) begin
      rd_v = u_far.got.pop_front();
      `CHK(rd_v, exp_q[i])
    end
    seed = lfsr(seed);
    u_far.push(seed, 12, 3'd3);
    idle(4);
    `CHK(link_fsm_state, `TFC_CODE_WAIT)
    `CHK(fill_count, 7'd12)
    rd(`TFC_OFS_CTRL, rd_v);
    `CHK(rd_v[2:0], 3'd3)
    for (int i = 0; i < 12; i++) begin
      rd(`TFC_OFS_DATA, rd_v);
      `CHK(rd_v, seed + 8'(i))
    end
    cmd_transceive = 1'b0;
    idle(2);
    `CHK(link_fsm_state, `TFC_CODE_IDLE)
    complete_run();
  end
endmodule
